/* File: core/cil_pkg.sv */
// Package: register map, field layout, reset values and timing of the interrupt logic
package cil_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PERIPH_FLAGS_ONE = 8'h04;
  localparam logic [7:0] OFS_PERIPH_FLAGS_TWO = 8'h08;
  localparam logic [7:0] OFS_PERIPH_ENABLES_ONE = 8'h0c;
  localparam logic [7:0] OFS_PERIPH_ENABLES_TWO = 8'h10;
  localparam logic [7:0] OFS_OPTION = 8'h14;
  localparam logic [7:0] OFS_CHANGE_PIN_SELECT = 8'h18;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h1c;
  localparam logic [7:0] OFS_EVT_MASK = 8'h20;
  // ----------------------------------------------------------------
  // interrupt_control bit positions
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PERIPH_EN = 6;
  localparam int BIT_TIMER_EN = 5;
  localparam int BIT_PIN_EN = 4;
  localparam int BIT_PORT_EN = 3;
  localparam int BIT_TIMER_FLAG = 2;
  localparam int BIT_PIN_FLAG = 1;
  localparam int BIT_PORT_FLAG = 0;
  // Option register: edge select position
  localparam int BIT_EDGE_SEL = 6;
  // Event status bits
  localparam int EVT_VECTOR = 0;
  localparam int EVT_WAKE = 1;
  localparam int EVT_SLEEP_NOP = 2;
  localparam int EVT_W = 3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPH = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_CHANGE_PIN_SELECT = 8'hf0;
  // ----------------------------------------------------------------
  // Timing and vector
  // ----------------------------------------------------------------
  localparam int CLKS_PER_INSTR = 4;
  localparam int LAT_INSTR_CYCLES = 3;
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;
  localparam logic [7:0] TIMER_MAX = 8'hff;
  localparam logic [7:0] TIMER_MIN = 8'h00;
endpackage

/* File: core/cil_instr_tick.sv */
// Instruction-cycle enable divider
`timescale 1ns/1ps
`default_nettype none
module cil_instr_tick #(
  parameter int DIV = cil_pkg::CLKS_PER_INSTR
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  initial begin
    if (DIV < 2 || DIV > 256) begin
      $error("DIV out of range");
    end
  end

  logic [7:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
    end else if (cnt_r == 8'(DIV - 1)) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign tick = (cnt_r == 8'(DIV - 1));
endmodule
`default_nettype wire

/* File: core/cil_src_detect.sv */
// Event detectors: external pin edge, timer wrap, port change
`timescale 1ns/1ps
`default_nettype none
module cil_src_detect #(
  parameter int PORT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_irq_pin,
  input wire logic ext_edge_select,
  input wire logic [7:0] timer_zero_count,
  input wire logic [PORT_W-1:0] second_port_pins,
  input wire logic [PORT_W-1:0] change_pin_select,
  output logic ext_edge,
  output logic timer_wrap,
  output logic port_change
);
  initial begin
    if (PORT_W < 1 || PORT_W > 8) begin
      $error("PORT_W out of range");
    end
  end

  // First cycle after reset only samples, so a pin high at reset is no edge
  logic primed_r;
  logic pin_r;
  logic [7:0] tmr_r;
  logic [PORT_W-1:0] port_r;
  logic [PORT_W-1:0] chg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primed_r <= 1'b0;
      pin_r <= 1'b0;
      tmr_r <= 8'h00;
      port_r <= '0;
    end else begin
      primed_r <= 1'b1;
      pin_r <= ext_irq_pin;
      tmr_r <= timer_zero_count;
      port_r <= second_port_pins;
    end
  end

  // Rising when edge select is set, falling otherwise
  assign ext_edge = primed_r && (ext_edge_select ? (ext_irq_pin && !pin_r) :
                                 (!ext_irq_pin && pin_r));
  assign timer_wrap = primed_r && (tmr_r == cil_pkg::TIMER_MAX) &&
                      (timer_zero_count == cil_pkg::TIMER_MIN);

  for (genvar i = 0; i < PORT_W; i++) begin : g_chg
    assign chg[i] = change_pin_select[i] && (second_port_pins[i] != port_r[i]);
  end

  assign port_change = primed_r && (|chg);
endmodule
`default_nettype wire

/* File: core/cil_core_irq.sv */
// Interrupt logic of the core: flags, enables, vectoring, sleep wake-up, APB registers
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Up to eleven sources, each with its own flag and enable bit.
// - A source event sets its flag regardless of any enable bit.
// - Global enable (control bit 7) permits unmasked interrupts; clear blocks all.
// - Global enable plus flag and enable set: interrupt is taken after three instruction cycles.
// - Every reset clears the global enable.
// - Taking an interrupt clears global enable, pushes return, loads 0004h.
// - Return-from-handler leaves the handler and sets global enable again.
// - Peripheral flags/enables in two register pairs, gated by peripheral enable.
// - Pin-edge and port-change latency is three or four instruction cycles.
// - External pin triggers rising with edge-select set, falling when clear.
// - A valid external edge sets the external flag, control bit 1.
// - External pin interrupt is masked by clearing control bit 4.
// - Pin wakes from sleep only if enabled before sleep; global enable decides vector.
// - Wake with global enable set loads the vector, else next instruction.
// - Timer wrap FFh to 00h sets flag bit 2; enable is bit 5.
// - Selected port pin change sets flag bit 0, gated by its own enable.
// - Enabled source wakes from sleep whatever the global enable state.
module cil_core_irq #(
  parameter int P1_W = 6,
  parameter int P2_W = 2,
  parameter int PORT_W = 8,
  parameter int CYC_DIV = cil_pkg::CLKS_PER_INSTR
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_irq_pin,
  input wire logic [PORT_W-1:0] second_port_pins,
  input wire logic [7:0] timer_zero_count,
  input wire logic [P1_W-1:0] periph_events_one,
  input wire logic [P2_W-1:0] periph_events_two,
  input wire logic sleep_enter,
  input wire logic return_from_handler,
  output logic vector_take,
  output logic push_return,
  output logic [12:0] pc_load_addr,
  output logic wake,
  output logic asleep,
  output logic irq
);
  initial begin
    if (P1_W < 1 || P1_W > 8 || P2_W < 1 || P2_W > 8 || P1_W + P2_W + 3 > 11) begin
      $error("Peripheral source count out of range");
    end
  end

  // ----------------------------------------------------------------
  // Registers and signals
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_LAT = 3'b010,
    ST_SLEEP = 3'b100
  } cil_state_t;

  cil_state_t state_r;
  logic [7:0] ictl_r;
  logic [P1_W-1:0] pflag1_r;
  logic [P2_W-1:0] pflag2_r;
  logic [P1_W-1:0] pen1_r;
  logic [P2_W-1:0] pen2_r;
  logic [7:0] option_r;
  logic [PORT_W-1:0] chg_sel_r;
  logic [cil_pkg::EVT_W-1:0] evt_r;
  logic [cil_pkg::EVT_W-1:0] evt_mask_r;
  logic [1:0] lat_cnt_r;
  logic pin_en_snap_r;
  logic vector_take_r;
  logic wake_r;
  logic [12:0] pc_load_addr_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic tick;
  logic ext_edge;
  logic timer_wrap;
  logic port_change;
  logic setup;
  logic wr;
  logic glb_en;
  logic periph_pending;
  logic any_pending;
  logic wake_cond;
  logic take_cond;
  logic fire;
  logic sleep_nop;
  logic sleep_go;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [7:0] ictl_nxt;
  logic [cil_pkg::EVT_W-1:0] evt_set;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  cil_instr_tick #(.DIV(CYC_DIV)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  cil_src_detect #(.PORT_W(PORT_W)) u_src (
    .pclk(pclk),
    .presetn(presetn),
    .ext_irq_pin(ext_irq_pin),
    .ext_edge_select(option_r[cil_pkg::BIT_EDGE_SEL]),
    .timer_zero_count(timer_zero_count),
    .second_port_pins(second_port_pins),
    .change_pin_select(chg_sel_r),
    .ext_edge(ext_edge),
    .timer_wrap(timer_wrap),
    .port_change(port_change)
  );

  // ----------------------------------------------------------------
  // Pending logic
  // ----------------------------------------------------------------
  assign glb_en = ictl_r[cil_pkg::BIT_GLOBAL_EN];
  assign periph_pending = ictl_r[cil_pkg::BIT_PERIPH_EN] &&
                          ((|(pflag1_r & pen1_r)) || (|(pflag2_r & pen2_r)));
  assign any_pending = periph_pending ||
    (ictl_r[cil_pkg::BIT_PIN_FLAG] && ictl_r[cil_pkg::BIT_PIN_EN]) ||
    (ictl_r[cil_pkg::BIT_TIMER_FLAG] && ictl_r[cil_pkg::BIT_TIMER_EN]) ||
    (ictl_r[cil_pkg::BIT_PORT_FLAG] && ictl_r[cil_pkg::BIT_PORT_EN]);
  // Pin wake uses the enable as it stood when sleep began
  assign wake_cond = periph_pending ||
    (ictl_r[cil_pkg::BIT_PIN_FLAG] && pin_en_snap_r) ||
    (ictl_r[cil_pkg::BIT_TIMER_FLAG] && ictl_r[cil_pkg::BIT_TIMER_EN]) ||
    (ictl_r[cil_pkg::BIT_PORT_FLAG] && ictl_r[cil_pkg::BIT_PORT_EN]);
  assign take_cond = glb_en && any_pending;
  assign fire = (state_r == ST_LAT) && take_cond && tick &&
                (lat_cnt_r == 2'(cil_pkg::LAT_INSTR_CYCLES - 1));
  assign sleep_nop = (state_r == ST_RUN) && sleep_enter && any_pending;
  assign sleep_go = (state_r == ST_RUN) && sleep_enter && !any_pending && !take_cond;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && !pslverr_r;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      cil_pkg::OFS_INTERRUPT_CONTROL: rd_mux[7:0] = ictl_r;
      cil_pkg::OFS_PERIPH_FLAGS_ONE: rd_mux[P1_W-1:0] = pflag1_r;
      cil_pkg::OFS_PERIPH_FLAGS_TWO: rd_mux[P2_W-1:0] = pflag2_r;
      cil_pkg::OFS_PERIPH_ENABLES_ONE: rd_mux[P1_W-1:0] = pen1_r;
      cil_pkg::OFS_PERIPH_ENABLES_TWO: rd_mux[P2_W-1:0] = pen2_r;
      cil_pkg::OFS_OPTION: rd_mux[7:0] = option_r;
      cil_pkg::OFS_CHANGE_PIN_SELECT: rd_mux[PORT_W-1:0] = chg_sel_r;
      cil_pkg::OFS_EVT_STATUS: rd_mux[cil_pkg::EVT_W-1:0] = evt_r;
      cil_pkg::OFS_EVT_MASK: rd_mux[cil_pkg::EVT_W-1:0] = evt_mask_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= !rd_hit || (paddr[1:0] != 2'b00);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt control register
  // ----------------------------------------------------------------
  always_comb begin
    ictl_nxt = ictl_r;
    if (wr && paddr == cil_pkg::OFS_INTERRUPT_CONTROL) begin
      ictl_nxt = pwdata[7:0];
    end
    if (return_from_handler) begin
      ictl_nxt[cil_pkg::BIT_GLOBAL_EN] = 1'b1;
    end
    // Taking the vector beats a same-cycle software or return set of the enable
    if (fire) begin
      ictl_nxt[cil_pkg::BIT_GLOBAL_EN] = 1'b0;
    end
    // Hardware sets win over a software clear in the same cycle
    if (ext_edge) begin
      ictl_nxt[cil_pkg::BIT_PIN_FLAG] = 1'b1;
    end
    if (timer_wrap) begin
      ictl_nxt[cil_pkg::BIT_TIMER_FLAG] = 1'b1;
    end
    if (port_change) begin
      ictl_nxt[cil_pkg::BIT_PORT_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ictl_r <= cil_pkg::RST_INTERRUPT_CONTROL;
    end else begin
      ictl_r <= ictl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral flag and enable pairs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pflag1_r <= P1_W'(cil_pkg::RST_PERIPH);
      pflag2_r <= P2_W'(cil_pkg::RST_PERIPH);
    end else begin
      pflag1_r <= ((wr && paddr == cil_pkg::OFS_PERIPH_FLAGS_ONE) ? pwdata[P1_W-1:0] :
                   pflag1_r) | periph_events_one;
      pflag2_r <= ((wr && paddr == cil_pkg::OFS_PERIPH_FLAGS_TWO) ? pwdata[P2_W-1:0] :
                   pflag2_r) | periph_events_two;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pen1_r <= P1_W'(cil_pkg::RST_PERIPH);
      pen2_r <= P2_W'(cil_pkg::RST_PERIPH);
      option_r <= cil_pkg::RST_OPTION;
      chg_sel_r <= PORT_W'(cil_pkg::RST_CHANGE_PIN_SELECT);
      evt_mask_r <= '0;
    end else if (wr) begin
      if (paddr == cil_pkg::OFS_PERIPH_ENABLES_ONE) begin
        pen1_r <= pwdata[P1_W-1:0];
      end
      if (paddr == cil_pkg::OFS_PERIPH_ENABLES_TWO) begin
        pen2_r <= pwdata[P2_W-1:0];
      end
      if (paddr == cil_pkg::OFS_OPTION) begin
        option_r <= pwdata[7:0];
      end
      if (paddr == cil_pkg::OFS_CHANGE_PIN_SELECT) begin
        chg_sel_r <= pwdata[PORT_W-1:0];
      end
      if (paddr == cil_pkg::OFS_EVT_MASK) begin
        evt_mask_r <= pwdata[cil_pkg::EVT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: latency, vectoring and sleep
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      lat_cnt_r <= 2'b00;
      pin_en_snap_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          lat_cnt_r <= 2'b00;
          if (take_cond) begin
            state_r <= ST_LAT;
          end else if (sleep_go) begin
            state_r <= ST_SLEEP;
            pin_en_snap_r <= ictl_r[cil_pkg::BIT_PIN_EN];
          end
        end
        ST_LAT: begin
          // A handler that drops the enable or clears the flag aborts the take
          if (!take_cond || fire) begin
            state_r <= ST_RUN;
          end else if (tick) begin
            lat_cnt_r <= lat_cnt_r + 2'b01;
          end
        end
        ST_SLEEP: begin
          if (wake_cond) begin
            state_r <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Wake resumes at the next instruction; with enable set the RUN state then vectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_take_r <= 1'b0;
      wake_r <= 1'b0;
      pc_load_addr_r <= 13'h0000;
    end else begin
      vector_take_r <= fire;
      wake_r <= (state_r == ST_SLEEP) && wake_cond;
      if (fire) begin
        pc_load_addr_r <= cil_pkg::VECTOR_ADDR;
      end
    end
  end

  assign vector_take = vector_take_r;
  assign push_return = vector_take_r;
  assign pc_load_addr = pc_load_addr_r;
  assign wake = wake_r;
  assign asleep = (state_r == ST_SLEEP);

  // ----------------------------------------------------------------
  // Event status, mask and interrupt line
  // ----------------------------------------------------------------
  assign evt_set = {sleep_nop, (state_r == ST_SLEEP) && wake_cond, fire};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r <= '0;
    end else if (wr && paddr == cil_pkg::OFS_EVT_STATUS) begin
      evt_r <= (evt_r & ~pwdata[cil_pkg::EVT_W-1:0]) | evt_set;
    end else begin
      evt_r <= evt_r | evt_set;
    end
  end

  assign irq = |(evt_r & evt_mask_r);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_VEC_CLEARS_GLB_EN: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take |-> !glb_en && $past(glb_en, 2))
    else $error("Vector taken without clearing global enable");

  AST_VEC_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take |-> push_return && pc_load_addr == cil_pkg::VECTOR_ADDR)
    else $error("Vector address or push wrong");

  AST_RFH_SETS_GLB_EN: assert property (@(posedge pclk) disable iff (!presetn)
    (return_from_handler && !fire) |=> glb_en)
    else $error("Return did not restore global enable");

  AST_NO_VEC_WHILE_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
    (!glb_en [*8]) |-> !vector_take)
    else $error("Vector taken while global enable clear");

  AST_EXT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    ext_edge |=> ictl_r[cil_pkg::BIT_PIN_FLAG])
    else $error("External edge did not set its flag");

  AST_TMR_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    timer_wrap |=> ictl_r[cil_pkg::BIT_TIMER_FLAG])
    else $error("Timer wrap did not set its flag");

  AST_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_RUN && take_cond) |-> ##[9:17] (vector_take || !take_cond))
    else $error("Interrupt latency outside three to four instruction cycles");

  AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (asleep && wake_cond) |=> !asleep ##0 wake)
    else $error("Enabled source did not wake the core");

  AST_VEC_NEEDS_PENDING: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take |-> $past(any_pending))
    else $error("Vector without a pending enabled source");

  AST_GLB_EN_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !glb_en)
    else $error("Global enable set after reset");

  COV_VECTOR: cover property (@(posedge pclk) disable iff (!presetn) vector_take);
  COV_WAKE_VEC: cover property (@(posedge pclk) disable iff (!presetn)
    wake ##[1:40] vector_take);
  COV_SLEEP_NOP: cover property (@(posedge pclk) disable iff (!presetn) sleep_nop);
  COV_RFH: cover property (@(posedge pclk) disable iff (!presetn)
    vector_take ##[1:40] return_from_handler);
endmodule
`default_nettype wire

/* File: tb/cil_core_model.sv */
// Core sequencer stand-in: issues sleep and return pulses, tracks vectors
`timescale 1ns/1ps
`default_nettype none
module cil_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic vector_take,
  input wire logic push_return,
  input wire logic [12:0] pc_load_addr,
  input wire logic wake,
  output logic sleep_enter,
  output logic return_from_handler
);
  int vec_n;
  int push_n;
  int wake_n;
  logic [12:0] last_pc;
  initial begin
    sleep_enter = 1'b0;
    return_from_handler = 1'b0;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_n <= 0;
      push_n <= 0;
      wake_n <= 0;
      last_pc <= 13'h0000;
    end else begin
      if (vector_take === 1'b1) begin
        vec_n <= vec_n + 1;
        last_pc <= pc_load_addr;
      end
      if (push_return === 1'b1) push_n <= push_n + 1;
      if (wake === 1'b1) wake_n <= wake_n + 1;
    end
  end
  task automatic pulse_sleep();
    sleep_enter <= 1'b1;
    @(posedge pclk);
    sleep_enter <= 1'b0;
  endtask
  // Return pulse re-arms the global enable inside the block
  task automatic pulse_ret();
    return_from_handler <= 1'b1;
    @(posedge pclk);
    return_from_handler <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/cil_core_irq_bench.sv */
// Self-checking bench of the core interrupt logic
`timescale 1ns/1ps
`default_nettype none
module cil_core_irq_bench;
  localparam logic [7:0] IC = cil_pkg::OFS_INTERRUPT_CONTROL;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_irq_pin;
  logic [7:0] paddr, second_port_pins, timer_zero_count;
  logic [31:0] pwdata, prdata, r;
  logic [5:0] periph_events_one;
  logic [1:0] periph_events_two;
  logic sleep_enter, return_from_handler, vector_take, push_return, wake, asleep, irq, e;
  logic [12:0] pc_load_addr;
  int mismatches, total_checks, cycles, n, v0;
  cil_core_irq DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_irq_pin, .second_port_pins, .timer_zero_count, .periph_events_one,
    .periph_events_two, .sleep_enter, .return_from_handler, .vector_take, .push_return,
    .pc_load_addr, .wake, .asleep, .irq);
  cil_core_model core (.pclk, .presetn, .vector_take, .push_return, .pc_load_addr, .wake,
    .sleep_enter, .return_from_handler);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Hang guard: well above the few hundred cycles the scenarios need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // Cycles until the next vector pulse, 99 if none within 40
  task automatic wait_vec(output int c);
    c = 99;
    for (int i = 1; i <= 40 && c == 99; i++) begin
      @(posedge pclk);
      if (vector_take === 1'b1) c = i;
    end
    idle(1);
  endtask
  task automatic t_reset();
    rd("control", IC, 32'h0);
    rd("option", cil_pkg::OFS_OPTION, 32'hff);
    rd("pin select", cil_pkg::OFS_CHANGE_PIN_SELECT, 32'hf0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    wr(IC, 8'h80);
    presetn <= 1'b0;
    idle(3);
    presetn <= 1'b1;
    idle(2);
    rd("control after reset", IC, 32'h0);
  endtask
  task automatic t_ext();
    ext_irq_pin <= 1'b1;
    idle(4);
    rd("flag without enable", IC, 32'h02);
    chk("no vector", 0, core.vec_n);
    wr(IC, 8'h92);
    wait_vec(n);
    chk("latency ok", 1, n >= 8 && n <= 18);
    rd("control in handler", IC, 32'h12);
    chk("vector addr", cil_pkg::VECTOR_ADDR, core.last_pc);
    chk("pushes", core.vec_n, core.push_n);
    core.pulse_ret();
    wait_vec(n);
    chk("retake", 1, n < 40);
    wr(IC, 8'h10);
    core.pulse_ret();
    idle(2);
    rd("return sets enable", IC, 32'h90);
    v0 = core.vec_n;
    ext_irq_pin <= 1'b0;
    idle(3);
    ext_irq_pin <= 1'b1;
    wait_vec(n);
    chk("pin latency", 1, n >= 9 && n <= 21);
  endtask
  task automatic t_mask();
    wr(cil_pkg::OFS_OPTION, 8'h00);
    wr(IC, 8'h80);
    v0 = core.vec_n;
    ext_irq_pin <= 1'b0;
    idle(30);
    rd("falling sets flag", IC, 32'h82);
    chk("masked pin", v0, core.vec_n);
    wr(IC, 8'h00);
    ext_irq_pin <= 1'b1;
    idle(4);
    rd("rising ignored", IC, 32'h00);
  endtask
  task automatic t_src();
    timer_zero_count <= 8'hff;
    idle(2);
    timer_zero_count <= 8'h00;
    idle(3);
    rd("timer flag", IC, 32'h04);
    wr(IC, 8'h00);
    second_port_pins <= 8'h01;
    idle(4);
    rd("unselected pin", IC, 32'h00);
    second_port_pins <= 8'h81;
    idle(4);
    rd("port flag", IC, 32'h01);
    wr(IC, 8'h00);
    periph_events_one <= 6'h20;
    periph_events_two <= 2'h2;
    @(posedge pclk);
    periph_events_one <= 6'h00;
    periph_events_two <= 2'h0;
    idle(2);
    rd("periph flags one", cil_pkg::OFS_PERIPH_FLAGS_ONE, 32'h20);
    rd("periph flags two", cil_pkg::OFS_PERIPH_FLAGS_TWO, 32'h2);
    wr(cil_pkg::OFS_PERIPH_ENABLES_ONE, 8'h20);
    wr(IC, 8'h80);
    v0 = core.vec_n;
    idle(30);
    chk("periph gate", v0, core.vec_n);
    wr(IC, 8'hc0);
    wait_vec(n);
    chk("periph vector", 1, n < 40);
    wr(cil_pkg::OFS_PERIPH_FLAGS_ONE, 8'h00);
  endtask
  task automatic t_sleep();
    wr(cil_pkg::OFS_OPTION, 8'h40);
    wr(IC, 8'h10);
    ext_irq_pin <= 1'b0;
    v0 = core.vec_n;
    n = core.wake_n;
    core.pulse_sleep();
    idle(3);
    chk("asleep", 1, asleep);
    ext_irq_pin <= 1'b1;
    idle(30);
    chk("wake", n + 1, core.wake_n);
    chk("no vector on wake", v0, core.vec_n);
    wr(IC, 8'h90);
    ext_irq_pin <= 1'b0;
    core.pulse_sleep();
    idle(3);
    ext_irq_pin <= 1'b1;
    idle(30);
    chk("vector on wake", v0 + 1, core.vec_n);
    rd("event status", cil_pkg::OFS_EVT_STATUS, 32'h3);
    wr(cil_pkg::OFS_EVT_MASK, 8'h01);
    chk("irq raised", 1, irq);
    wr(cil_pkg::OFS_EVT_STATUS, 8'h03);
    idle(1);
    chk("irq cleared", 0, irq);
    core.pulse_sleep();
    idle(2);
    chk("sleep as nop", 0, asleep);
    rd("nop event", cil_pkg::OFS_EVT_STATUS, 32'h4);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, ext_irq_pin} = 4'h0;
    {paddr, second_port_pins, timer_zero_count, pwdata} = '0;
    {periph_events_one, periph_events_two} = 8'h0;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    idle(20);
    presetn <= 1'b1;
    idle(2);
    t_reset();
    t_ext();
    t_mask();
    t_src();
    t_sleep();
    complete_run();
  end
endmodule
`default_nettype wire
